// >>> i2s_clkgen.sv
`timescale 1ns/1ps
`include "i2s_consts.svh"
module i2s_clkgen
  import i2s_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Configuration.
  input wire logic run_i,
  input wire logic master_i,
  input wire logic fedge_i,
  input wire logic [7:0] sdiv_i,
  input wire logic [7:0] mdiv_i,
  input wire logic [7:0] bdiv_i,
  // External clocks in internal polarity.
  input wire logic ext_bclk_i,
  input wire logic ext_lrck_i,
  // Generated clocks and events.
  output logic mclk_ph_o,
  output logic bclk_o,
  output logic lrck_o,
  output logic bclk_rise_o,
  output logic bclk_fall_o,
  output logic lrck_chg_o
);
  logic [7:0] sys_cnt_q;
  logic [8:0] mt_cnt_q;
  logic [7:0] fr_cnt_q;
  logic mclk_q;
  logic bclk_q;
  logic lrck_q;
  logic rise_q;
  logic fall_q;
  logic chg_q;

  wire mclk_tick = (sdiv_i != 8'h00) && (sys_cnt_q == sdiv_i - 8'h01);
  wire [8:0] bhalf = (sdiv_i == 8'h01) ? {1'b0, mdiv_i} : {mdiv_i, 1'b0};
  wire bclk_tick = mclk_tick && (mdiv_i != 8'h00) && (mt_cnt_q == bhalf - 9'h001);
  wire frame_edge = bclk_tick && (fedge_i ? ~bclk_q : bclk_q);
  wire lrck_tick = frame_edge && (bdiv_i != 8'h00) && (fr_cnt_q == bdiv_i - 8'h01);
  wire next_bclk = master_i ? (bclk_q ^ bclk_tick) : ext_bclk_i;
  wire next_lrck = master_i ? (lrck_q ^ lrck_tick) : ext_lrck_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_cnt_q <= 8'h00;
      mt_cnt_q <= 9'h000;
      fr_cnt_q <= 8'h00;
      mclk_q <= 1'b0;
      bclk_q <= 1'b0;
      lrck_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      chg_q <= 1'b0;
    end else if (!run_i) begin
      // Idle levels while disabled.
      sys_cnt_q <= 8'h00;
      mt_cnt_q <= 9'h000;
      fr_cnt_q <= 8'h00;
      mclk_q <= 1'b0;
      bclk_q <= 1'b0;
      lrck_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      chg_q <= 1'b0;
    end else begin
      sys_cnt_q <= mclk_tick ? 8'h00 : sys_cnt_q + 8'h01;
      mclk_q <= master_i & (mclk_q ^ mclk_tick);
      if (mclk_tick) begin
        mt_cnt_q <= bclk_tick ? 9'h000 : mt_cnt_q + 9'h001;
      end
      if (frame_edge) begin
        fr_cnt_q <= lrck_tick ? 8'h00 : fr_cnt_q + 8'h01;
      end
      bclk_q <= next_bclk;
      lrck_q <= next_lrck;
      rise_q <= next_bclk & ~bclk_q;
      fall_q <= ~next_bclk & bclk_q;
      chg_q <= next_lrck ^ lrck_q;
    end
  end

  assign mclk_ph_o = mclk_q;
  assign bclk_o = bclk_q;
  assign lrck_o = lrck_q;
  assign bclk_rise_o = rise_q;
  assign bclk_fall_o = fall_q;
  assign lrck_chg_o = chg_q;
endmodule : i2s_clkgen

// >>> i2s_consts.svh
// Behaviour
// - Samples leave MSB first, left word before right unless swap is selected.
// - Standard framing: frame clock low for left, high for right, changes on falling edge.
// - Left justified: left word while frame clock high; data changes on rising edge.
// - Right justified: word ends with its LSB just before the frame clock toggles.
// - Master select 1 generates all clocks; 0 takes external clocks; resets to 1.
// - Format field: 0 standard, 1 right, 2 left justified, 3 reserved; resets to 2.
// - Swap sends right word first; frame polarity inverts which level marks left.
// - Bit clock polarity inverts the bit clock, moving the data change edge.
// - Master clock is system clock over twice the first divider; none when zero.
// - Bit clock is master clock over second divider, or twice it; none when zero.
// - Frame clock is bit clock over twice the third divider; none when zero.
// - A slave port with clock sharing takes its clocks from the other port.
// - Master clock idle level bit: 0 rests high, 1 rests low; tx resets 1, rx 0.
// - Frame edge select: frame clock changes on falling edge at 0, rising at 1.
// - Sample width bit picks 16-bit samples at 1 and 8-bit samples at 0.
// - Transmit feed enable passes voice samples; at 0 software supplies data; resets 1.
// - Receive forward enable passes samples to the voice block; at 0 withholds them.
// - Channel mode: 0 both zero, 1 right only, 2 left only, 3 both channels.
// - Block enable turns the port on; resets to 0 so both ports start off.
`ifndef I2S_CONSTS_SVH
`define I2S_CONSTS_SVH
`define TX_CTRL_ADDR 16'h2528
`define TX_SDIV_ADDR 16'h252A
`define TX_MDIV_ADDR 16'h252B
`define TX_BDIV_ADDR 16'h252C
`define TX_MODE_ADDR 16'h252D
`define TX_SOFT_LO_ADDR 16'h252E
`define TX_SOFT_HI_ADDR 16'h252F
`define RX_CTRL_ADDR 16'h2538
`define RX_SDIV_ADDR 16'h253A
`define RX_MDIV_ADDR 16'h253B
`define RX_BDIV_ADDR 16'h253C
`define RX_MODE_ADDR 16'h253D
`define RX_SAMP_LO_ADDR 16'h253E
`define RX_SAMP_HI_ADDR 16'h253F
`define F_MS 7
`define F_FMT_HI 6
`define F_FMT_LO 5
`define F_WL_HI 4
`define F_WL_LO 3
`define F_SWAP 2
`define F_FRAME_POLARITY 1
`define F_BCP 0
`define F_SHARE 7
`define F_MIDLE 6
`define F_FEDGE 5
`define F_SW16 4
`define F_FEED 3
`define F_CM_HI 2
`define F_CM_LO 1
`define F_EN 0
`define TX_CTRL_RST 8'hC0
`define TX_MODE_RST 8'h7E
`define RX_CTRL_RST 8'hC0
`define RX_MODE_RST 8'h00
`define DIV_RST 8'h00
`define SAMPLE_RST 16'h0000
`endif

// >>> i2s_converter_model.sv
`timescale 1ns/1ps
module i2s_converter_model (
  // Converter input side, fed by the transmit port.
  input wire logic dac_bclk_i, dac_lrck_i, dac_sd_i,
  // Converter output side, clocked by the receive port.
  input wire logic adc_bclk_i, adc_lrck_i,
  input wire logic [15:0] next_word_i,
  output logic adc_sd_o,
  output logic [15:0] got_o,
  output int got_cnt_o,
  output int loads_o
);
  logic dac_lr_q = 1'b0, adc_lr_q = 1'b0, seen = 1'b0;
  logic [15:0] sh = 16'h0000;
  logic [32:0] out_sh = 33'h0;
  int cnt = 0;
  initial {adc_sd_o, got_o, got_cnt_o, loads_o} = '0;
  // The 16 bits after the delay bit form the word; the rest of the slot is padding.
  always @(posedge dac_bclk_i) begin
    if (dac_lrck_i !== dac_lr_q) begin
      if (seen) got_o = sh;
      if (seen) got_cnt_o++;
      seen = 1'b1;
      cnt = 0;
      dac_lr_q = dac_lrck_i;
    end else begin
      cnt++;
      if (cnt <= 16) sh = {sh[14:0], dac_sd_i};
    end
  end
  // Outside the word the line carries the fixed A5C3 filler and then complemented bits, so a late capture never sees a stale bit.
  always @(negedge adc_bclk_i) begin
    #1;
    if (adc_lrck_i !== adc_lr_q) begin
      adc_lr_q = adc_lrck_i;
      out_sh = {~adc_sd_o, next_word_i, 16'hA5C3};
      loads_o++;
    end
    adc_sd_o = out_sh[32];
    out_sh = {out_sh[31:0], ~out_sh[32]};
  end
endmodule : i2s_converter_model

// >>> i2s_pkg.sv
package i2s_pkg;
  typedef enum logic [1:0] {fmt_standard, fmt_right, fmt_left, fmt_reserved} fmt_type;
  typedef enum logic [1:0] {cm_blank, cm_right_only, cm_left_only, cm_both} chan_mode_type;

  function automatic logic [5:0] wl_bits(input logic [1:0] code);
    case (code)
      2'h0: wl_bits = 6'h10;
      2'h1: wl_bits = 6'h14;
      2'h2: wl_bits = 6'h18;
      default: wl_bits = 6'h20;
    endcase
  endfunction : wl_bits

  function automatic logic chan_left(input fmt_type fmt, input logic lrck, input logic frame_polarity);
    chan_left = ((fmt == fmt_standard) ? ~lrck : lrck) ^ frame_polarity;
  endfunction : chan_left

  function automatic logic chan_keep(input chan_mode_type cm, input logic left);
    chan_keep = (cm == cm_both) || (cm == cm_left_only && left) || (cm == cm_right_only && !left);
  endfunction : chan_keep
endpackage : i2s_pkg

// >>> i2s_tx_rx_interface.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "i2s_consts.svh"
module i2s_tx_rx_interface
  import i2s_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port.
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Transmit port pins.
  input wire logic tx_mclk_i,
  output logic tx_mclk_o,
  output logic tx_mclk_oe_o,
  input wire logic tx_bclk_i,
  output logic tx_bclk_o,
  output logic tx_bclk_oe_o,
  input wire logic tx_lrck_i,
  output logic tx_lrck_o,
  output logic tx_lrck_oe_o,
  output logic tx_sd_o,
  // Receive port pins.
  input wire logic rx_mclk_i,
  output logic rx_mclk_o,
  output logic rx_mclk_oe_o,
  input wire logic rx_bclk_i,
  output logic rx_bclk_o,
  output logic rx_bclk_oe_o,
  input wire logic rx_lrck_i,
  output logic rx_lrck_o,
  output logic rx_lrck_oe_o,
  input wire logic rx_sd_i,
  // Voice block sample transfer.
  input wire logic [15:0] tx_sample_i,
  output logic tx_pop_o,
  output logic [15:0] rx_sample_o,
  output logic rx_push_o
);
  // Registers.
  logic [7:0] tx_ctrl_q, tx_sdiv_q, tx_mdiv_q, tx_bdiv_q, tx_mode_q;
  logic [7:0] rx_ctrl_q, rx_sdiv_q, rx_mdiv_q, rx_bdiv_q, rx_mode_q;
  logic [15:0] tx_soft_q, rx_sample_q;
  logic [7:0] rdata_q, rdata_d;

  // Pin synchronisers: tx mclk, tx bclk, tx lrck, rx mclk, rx bclk, rx lrck, rx data.
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic [6:0] sync3_q;
  logic [6:0] pin_q;
  wire [6:0] pin_raw = {rx_sd_i, rx_lrck_i, rx_bclk_i, rx_mclk_i, tx_lrck_i, tx_bclk_i, tx_mclk_i};
  wire [6:0] pin_agree = ~(sync2_q ^ sync3_q);
  wire [6:0] pin_d = (pin_agree & sync3_q) | (~pin_agree & pin_q);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      sync3_q <= 7'h00;
      pin_q <= 7'h00;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= pin_d;
    end
  end

  // Field decoding.
  wire tx_run = tx_mode_q[`F_EN];
  wire rx_run = rx_mode_q[`F_EN];
  wire tx_master = tx_ctrl_q[`F_MS];
  wire rx_master = rx_ctrl_q[`F_MS];
  wire tx_bcp = tx_ctrl_q[`F_BCP];
  wire rx_bcp = rx_ctrl_q[`F_BCP];
  wire tx_share = ~tx_master & tx_mode_q[`F_SHARE];
  wire rx_share = ~rx_master & rx_mode_q[`F_SHARE];
  wire fmt_type tx_fmt = fmt_type'(tx_ctrl_q[`F_FMT_HI:`F_FMT_LO]);
  wire fmt_type rx_fmt = fmt_type'(rx_ctrl_q[`F_FMT_HI:`F_FMT_LO]);
  wire chan_mode_type tx_cm = chan_mode_type'(tx_mode_q[`F_CM_HI:`F_CM_LO]);
  wire chan_mode_type rx_cm = chan_mode_type'(rx_mode_q[`F_CM_HI:`F_CM_LO]);
  wire [5:0] tx_wl = wl_bits(tx_ctrl_q[`F_WL_HI:`F_WL_LO]);
  wire [5:0] rx_wl = wl_bits(rx_ctrl_q[`F_WL_HI:`F_WL_LO]);

  // Clock generation and sharing.
  logic tx_g_mclk, tx_g_bclk, tx_g_lrck, tx_g_rise, tx_g_fall, tx_g_chg;
  logic rx_g_mclk, rx_g_bclk, rx_g_lrck, rx_g_rise, rx_g_fall, rx_g_chg;
  // A shared clock is taken in pin polarity from the other port, then mapped to this port's polarity.
  wire tx_ext_bclk = (tx_share ? (rx_g_bclk ^ rx_bcp) : pin_q[1]) ^ tx_bcp;
  wire tx_ext_lrck = tx_share ? rx_g_lrck : pin_q[2];
  wire rx_ext_bclk = (rx_share ? (tx_g_bclk ^ tx_bcp) : pin_q[4]) ^ rx_bcp;
  wire rx_ext_lrck = rx_share ? tx_g_lrck : pin_q[5];

  i2s_clkgen tx_gen (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(tx_run),
    .master_i(tx_master),
    .fedge_i(tx_mode_q[`F_FEDGE]),
    .sdiv_i(tx_sdiv_q),
    .mdiv_i(tx_mdiv_q),
    .bdiv_i(tx_bdiv_q),
    .ext_bclk_i(tx_ext_bclk),
    .ext_lrck_i(tx_ext_lrck),
    .mclk_ph_o(tx_g_mclk),
    .bclk_o(tx_g_bclk),
    .lrck_o(tx_g_lrck),
    .bclk_rise_o(tx_g_rise),
    .bclk_fall_o(tx_g_fall),
    .lrck_chg_o(tx_g_chg)
  );

  i2s_clkgen rx_gen (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(rx_run),
    .master_i(rx_master),
    .fedge_i(rx_mode_q[`F_FEDGE]),
    .sdiv_i(rx_sdiv_q),
    .mdiv_i(rx_mdiv_q),
    .bdiv_i(rx_bdiv_q),
    .ext_bclk_i(rx_ext_bclk),
    .ext_lrck_i(rx_ext_lrck),
    .mclk_ph_o(rx_g_mclk),
    .bclk_o(rx_g_bclk),
    .lrck_o(rx_g_lrck),
    .bclk_rise_o(rx_g_rise),
    .bclk_fall_o(rx_g_fall),
    .lrck_chg_o(rx_g_chg)
  );

  // Transmit serialiser.
  logic [31:0] tx_sr_q;
  logic [7:0] tx_pad_q;
  logic [7:0] tx_slot_q;
  logic [7:0] tx_len_q;
  logic tx_sd_q;
  logic tx_pop_q;
  wire tx_dedge = (tx_fmt == fmt_standard) ? tx_g_fall : tx_g_rise;
  wire tx_left = chan_left(tx_fmt, tx_g_lrck, tx_ctrl_q[`F_FRAME_POLARITY]) ^ tx_ctrl_q[`F_SWAP];
  wire tx_feed = tx_mode_q[`F_FEED];
  wire [15:0] tx_samp = tx_feed ? tx_sample_i : tx_soft_q;
  wire [31:0] tx_w32 = tx_mode_q[`F_SW16] ? {tx_samp, 16'h0000} : {tx_samp[7:0], 24'h000000};
  wire [31:0] tx_word = chan_keep(tx_cm, tx_left) ? tx_w32 : 32'h00000000;
  wire [7:0] tx_len_now = tx_slot_q + {7'h00, tx_dedge};
  // Right justified words start late by the slack between the half-frame and the word.
  wire tx_rj_pad = (tx_fmt == fmt_right) && (tx_len_q > {2'b00, tx_wl});
  wire [7:0] tx_pad_load = tx_rj_pad ? tx_len_q - {2'b00, tx_wl} : 8'h00;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_sr_q <= 32'h00000000;
      tx_pad_q <= 8'h00;
      tx_slot_q <= 8'h00;
      tx_len_q <= 8'h00;
      tx_sd_q <= 1'b0;
      tx_pop_q <= 1'b0;
    end else if (!tx_run) begin
      tx_sr_q <= 32'h00000000;
      tx_pad_q <= 8'h00;
      tx_slot_q <= 8'h00;
      tx_len_q <= 8'h00;
      tx_sd_q <= 1'b0;
      tx_pop_q <= 1'b0;
    end else begin
      tx_pop_q <= tx_g_chg & tx_feed;
      if (tx_dedge) begin
        tx_sd_q <= (tx_pad_q != 8'h00) ? 1'b0 : tx_sr_q[31];
        tx_slot_q <= tx_slot_q + 8'h01;
        if (tx_pad_q != 8'h00) begin
          tx_pad_q <= tx_pad_q - 8'h01;
        end else begin
          tx_sr_q <= {tx_sr_q[30:0], 1'b0};
        end
      end
      // The bit on a coincident data edge still belongs to the word that ends.
      if (tx_g_chg) begin
        tx_sr_q <= tx_word;
        tx_pad_q <= tx_pad_load;
        tx_len_q <= tx_len_now;
        tx_slot_q <= 8'h00;
      end
    end
  end

  // Receive deserialiser.
  logic [31:0] rx_sr_q;
  logic [5:0] rx_cnt_q;
  logic rx_pend_q;
  logic rx_prev_left_q;
  logic [15:0] rx_out_q;
  logic rx_push_q;
  wire rx_cedge = (rx_fmt == fmt_standard) ? rx_g_rise : rx_g_fall;
  wire rx_left_now = chan_left(rx_fmt, rx_g_lrck, rx_ctrl_q[`F_FRAME_POLARITY]) ^ rx_ctrl_q[`F_SWAP];
  wire rx_done_left = rx_g_chg ? ~rx_left_now : rx_prev_left_q;
  wire rx_take = (rx_fmt == fmt_right) || (rx_cnt_q < rx_wl);
  wire [31:0] rx_sr_next = {rx_sr_q[30:0], pin_q[6]};
  wire [31:0] rx_word = rx_take ? rx_sr_next : rx_sr_q;
  wire rx_final = rx_cedge & (rx_pend_q | rx_g_chg);
  logic [15:0] rx_aligned;
  always_comb begin
    case (rx_ctrl_q[`F_WL_HI:`F_WL_LO])
      2'h0: rx_aligned = rx_word[15:0];
      2'h1: rx_aligned = rx_word[19:4];
      2'h2: rx_aligned = rx_word[23:8];
      default: rx_aligned = rx_word[31:16];
    endcase
  end
  wire [15:0] rx_kept = chan_keep(rx_cm, rx_done_left) ? rx_aligned : 16'h0000;
  wire [15:0] rx_fmt_samp = rx_mode_q[`F_SW16] ? rx_kept : {8'h00, rx_kept[15:8]};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_sr_q <= 32'h00000000;
      rx_cnt_q <= 6'h00;
      rx_pend_q <= 1'b0;
      rx_prev_left_q <= 1'b0;
      rx_out_q <= `SAMPLE_RST;
      rx_push_q <= 1'b0;
      rx_sample_q <= `SAMPLE_RST;
    end else if (!rx_run) begin
      rx_sr_q <= 32'h00000000;
      rx_cnt_q <= 6'h00;
      rx_pend_q <= 1'b0;
      rx_push_q <= 1'b0;
    end else begin
      rx_push_q <= rx_final & rx_mode_q[`F_FEED];
      if (rx_g_chg) begin
        rx_prev_left_q <= ~rx_left_now;
      end
      if (rx_final) begin
        rx_sample_q <= rx_fmt_samp;
        if (rx_mode_q[`F_FEED]) begin
          rx_out_q <= rx_fmt_samp;
        end
        rx_sr_q <= 32'h00000000;
        rx_cnt_q <= 6'h00;
        rx_pend_q <= 1'b0;
      end else begin
        rx_pend_q <= rx_pend_q | rx_g_chg;
        if (rx_cedge && rx_take) begin
          rx_sr_q <= rx_sr_next;
          rx_cnt_q <= (rx_cnt_q == 6'h3F) ? rx_cnt_q : rx_cnt_q + 6'h01;
        end
      end
    end
  end

  // Pin outputs.
  logic tx_mclk_q, tx_bclk_q, tx_lrck_q, tx_oe_q, rx_mclk_q, rx_bclk_q, rx_lrck_q, rx_oe_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_mclk_q <= 1'b0;
      tx_bclk_q <= 1'b0;
      tx_lrck_q <= 1'b0;
      tx_oe_q <= 1'b0;
      rx_mclk_q <= 1'b0;
      rx_bclk_q <= 1'b0;
      rx_lrck_q <= 1'b0;
      rx_oe_q <= 1'b0;
    end else begin
      tx_mclk_q <= tx_g_mclk ^ ~tx_mode_q[`F_MIDLE];
      tx_bclk_q <= tx_g_bclk ^ tx_bcp;
      tx_lrck_q <= tx_g_lrck;
      tx_oe_q <= tx_master;
      rx_mclk_q <= rx_g_mclk ^ ~rx_mode_q[`F_MIDLE];
      rx_bclk_q <= rx_g_bclk ^ rx_bcp;
      rx_lrck_q <= rx_g_lrck;
      rx_oe_q <= rx_master;
    end
  end

  // Register port.
  wire wr_tx_ctrl = wr_i && (addr_i == `TX_CTRL_ADDR);
  wire wr_tx_sdiv = wr_i && (addr_i == `TX_SDIV_ADDR);
  wire wr_tx_mdiv = wr_i && (addr_i == `TX_MDIV_ADDR);
  wire wr_tx_bdiv = wr_i && (addr_i == `TX_BDIV_ADDR);
  wire wr_tx_mode = wr_i && (addr_i == `TX_MODE_ADDR);
  wire wr_tx_lo = wr_i && (addr_i == `TX_SOFT_LO_ADDR);
  wire wr_tx_hi = wr_i && (addr_i == `TX_SOFT_HI_ADDR);
  wire wr_rx_ctrl = wr_i && (addr_i == `RX_CTRL_ADDR);
  wire wr_rx_sdiv = wr_i && (addr_i == `RX_SDIV_ADDR);
  wire wr_rx_mdiv = wr_i && (addr_i == `RX_MDIV_ADDR);
  wire wr_rx_bdiv = wr_i && (addr_i == `RX_BDIV_ADDR);
  wire wr_rx_mode = wr_i && (addr_i == `RX_MODE_ADDR);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_ctrl_q <= `TX_CTRL_RST;
      tx_sdiv_q <= `DIV_RST;
      tx_mdiv_q <= `DIV_RST;
      tx_bdiv_q <= `DIV_RST;
      tx_mode_q <= `TX_MODE_RST;
      tx_soft_q <= `SAMPLE_RST;
      rx_ctrl_q <= `RX_CTRL_RST;
      rx_sdiv_q <= `DIV_RST;
      rx_mdiv_q <= `DIV_RST;
      rx_bdiv_q <= `DIV_RST;
      rx_mode_q <= `RX_MODE_RST;
    end else begin
      if (wr_tx_ctrl) tx_ctrl_q <= wdata_i;
      if (wr_tx_sdiv) tx_sdiv_q <= wdata_i;
      if (wr_tx_mdiv) tx_mdiv_q <= wdata_i;
      if (wr_tx_bdiv) tx_bdiv_q <= wdata_i;
      if (wr_tx_mode) tx_mode_q <= wdata_i;
      if (wr_tx_lo) tx_soft_q[7:0] <= wdata_i;
      if (wr_tx_hi) tx_soft_q[15:8] <= wdata_i;
      if (wr_rx_ctrl) rx_ctrl_q <= wdata_i;
      if (wr_rx_sdiv) rx_sdiv_q <= wdata_i;
      if (wr_rx_mdiv) rx_mdiv_q <= wdata_i;
      if (wr_rx_bdiv) rx_bdiv_q <= wdata_i;
      if (wr_rx_mode) rx_mode_q <= wdata_i;
    end
  end

  always_comb begin
    if (addr_i == `TX_CTRL_ADDR) rdata_d = tx_ctrl_q;
    else if (addr_i == `TX_SDIV_ADDR) rdata_d = tx_sdiv_q;
    else if (addr_i == `TX_MDIV_ADDR) rdata_d = tx_mdiv_q;
    else if (addr_i == `TX_BDIV_ADDR) rdata_d = tx_bdiv_q;
    else if (addr_i == `TX_MODE_ADDR) rdata_d = tx_mode_q;
    else if (addr_i == `TX_SOFT_LO_ADDR) rdata_d = tx_soft_q[7:0];
    else if (addr_i == `TX_SOFT_HI_ADDR) rdata_d = tx_soft_q[15:8];
    else if (addr_i == `RX_CTRL_ADDR) rdata_d = rx_ctrl_q;
    else if (addr_i == `RX_SDIV_ADDR) rdata_d = rx_sdiv_q;
    else if (addr_i == `RX_MDIV_ADDR) rdata_d = rx_mdiv_q;
    else if (addr_i == `RX_BDIV_ADDR) rdata_d = rx_bdiv_q;
    else if (addr_i == `RX_MODE_ADDR) rdata_d = rx_mode_q;
    else if (addr_i == `RX_SAMP_LO_ADDR) rdata_d = rx_sample_q[7:0];
    else if (addr_i == `RX_SAMP_HI_ADDR) rdata_d = rx_sample_q[15:8];
    else rdata_d = 8'h00;
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_i ? rdata_d : 8'h00;
    end
  end

  assign rdata_o = rdata_q;
  assign tx_mclk_o = tx_mclk_q;
  assign tx_mclk_oe_o = tx_oe_q;
  assign tx_bclk_o = tx_bclk_q;
  assign tx_bclk_oe_o = tx_oe_q;
  assign tx_lrck_o = tx_lrck_q;
  assign tx_lrck_oe_o = tx_oe_q;
  assign tx_sd_o = tx_sd_q;
  assign rx_mclk_o = rx_mclk_q;
  assign rx_mclk_oe_o = rx_oe_q;
  assign rx_bclk_o = rx_bclk_q;
  assign rx_bclk_oe_o = rx_oe_q;
  assign rx_lrck_o = rx_lrck_q;
  assign rx_lrck_oe_o = rx_oe_q;
  assign tx_pop_o = tx_pop_q;
  assign rx_sample_o = rx_out_q;
  assign rx_push_o = rx_push_q;
endmodule : i2s_tx_rx_interface

// >>> i2s_tx_rx_interface_assertions.sv
`timescale 1ns/1ps
`include "i2s_consts.svh"
module i2s_tx_rx_checker (
  // Clock, reset and register port.
  input wire logic clk_i, reset_n_i, wr_i, rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i, rdata_o,
  // Pins and voice side.
  input wire logic tx_mclk_oe_o, tx_bclk_oe_o, tx_lrck_oe_o, tx_bclk_o, tx_lrck_o, tx_sd_o,
  input wire logic rx_lrck_o, tx_pop_o, rx_push_o
);
  logic tx_en_q, rx_en_q, rx_fwd_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Shadow of the enable bits, taken from the register writes.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {tx_en_q, rx_en_q, rx_fwd_q} <= 3'h0;
    end else if (wr_i) begin
      if (addr_i == `TX_MODE_ADDR) tx_en_q <= wdata_i[`F_EN];
      if (addr_i == `RX_MODE_ADDR) {rx_fwd_q, rx_en_q} <= {wdata_i[`F_FEED], wdata_i[`F_EN]};
    end
  end
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  AST_OE_SAME: assert property (tx_mclk_oe_o == tx_bclk_oe_o && tx_bclk_oe_o == tx_lrck_oe_o)
    else $error("enables disagree");
  AST_OE_MS: assert property (wr_i && addr_i == `TX_CTRL_ADDR |-> ##2 tx_bclk_oe_o == $past(wdata_i[`F_MS], 2))
    else $error("enable not master bit");
  AST_TX_OFF: assert property (!tx_en_q && !$past(tx_en_q, 3) |-> !tx_sd_o && !tx_lrck_o)
    else $error("tx active while off");
  AST_RX_OFF: assert property (!rx_en_q && !$past(rx_en_q, 3) |-> !rx_push_o && !rx_lrck_o)
    else $error("rx active while off");
  AST_SD_EDGE: assert property (tx_en_q && $past(tx_en_q, 3) && $changed(tx_sd_o) |-> $fell(tx_bclk_o))
    else $error("data off falling edge");
  AST_LR_EDGE: assert property (tx_en_q && $past(tx_en_q, 3) && $changed(tx_lrck_o) |-> $fell(tx_bclk_o))
    else $error("frame off falling edge");
  AST_POP_ONE: assert property (tx_pop_o |=> !tx_pop_o)
    else $error("pop too long");
  AST_PUSH_GATE: assert property (rx_push_o |-> rx_fwd_q || $past(rx_fwd_q))
    else $error("push while withheld");
  cover property (tx_pop_o);
  cover property (rx_push_o);
  cover property ($rose(tx_lrck_o));
endmodule : i2s_tx_rx_checker

// >>> i2s_tx_rx_interface_tb.sv
`timescale 1ns/1ps
`include "i2s_consts.svh"
module i2s_tx_rx_interface_tb;
  logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [15:0] addr_i = 16'h0000, tx_sample_i, rx_sample_o, got, src[64], tx_exp_q[$];
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic tx_mclk_o, tx_mclk_oe_o, tx_bclk_o, tx_bclk_oe_o, tx_lrck_o, tx_lrck_oe_o, tx_sd_o;
  logic rx_mclk_o, rx_mclk_oe_o, rx_bclk_o, rx_bclk_oe_o, rx_lrck_o, rx_lrck_oe_o, rx_sd_i;
  logic tx_pop_o, rx_push_o;
  logic [2:0] prev = 3'h0;
  integer seed = 32'h274D056C;
  int err_count = 0, checks = 0, got_cnt, loads, npush = 0;
  int cyc = 0, t_m = 0, t_b = 0, t_l = 0, p_m = 0, p_b = 0, p_l = 0;
  // Address, reset value and run value of each register; the last two are unmapped.
  logic [15:0] ra[12] = '{`TX_CTRL_ADDR, `TX_SDIV_ADDR, `TX_MDIV_ADDR, `TX_BDIV_ADDR, `TX_MODE_ADDR,
    `RX_CTRL_ADDR, `RX_SDIV_ADDR, `RX_MDIV_ADDR, `RX_BDIV_ADDR, `RX_MODE_ADDR, 16'h2529, 16'h2530};
  logic [7:0] rv[12] = '{8'hC0, 8'h00, 8'h00, 8'h00, 8'h7E, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] cv[12] = '{8'h80, 8'h03, 8'h02, 8'h14, 8'h5F, 8'h80, 8'h03, 8'h02, 8'h14, 8'h17, 8'hFF, 8'hFF};
  always #10 clk_i = ~clk_i;
  // Slave clock inputs take the other port's clocks so that they carry live edges.
  i2s_tx_rx_interface i2s_tx_rx_interface_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_mclk_i(rx_mclk_o), .tx_mclk_o(tx_mclk_o),
    .tx_mclk_oe_o(tx_mclk_oe_o), .tx_bclk_i(rx_bclk_o), .tx_bclk_o(tx_bclk_o), .tx_bclk_oe_o(tx_bclk_oe_o),
    .tx_lrck_i(rx_lrck_o), .tx_lrck_o(tx_lrck_o), .tx_lrck_oe_o(tx_lrck_oe_o), .tx_sd_o(tx_sd_o),
    .rx_mclk_i(tx_mclk_o), .rx_mclk_o(rx_mclk_o), .rx_mclk_oe_o(rx_mclk_oe_o), .rx_bclk_i(tx_bclk_o),
    .rx_bclk_o(rx_bclk_o), .rx_bclk_oe_o(rx_bclk_oe_o), .rx_lrck_i(tx_lrck_o), .rx_lrck_o(rx_lrck_o),
    .rx_lrck_oe_o(rx_lrck_oe_o), .rx_sd_i(rx_sd_i), .tx_sample_i(tx_sample_i), .tx_pop_o(tx_pop_o),
    .rx_sample_o(rx_sample_o), .rx_push_o(rx_push_o));
  i2s_converter_model i2s_converter_model_inst (.dac_bclk_i(tx_bclk_o), .dac_lrck_i(tx_lrck_o),
    .dac_sd_i(tx_sd_o), .adc_bclk_i(rx_bclk_o), .adc_lrck_i(rx_lrck_o), .next_word_i(src[loads % 64]),
    .adc_sd_o(rx_sd_i), .got_o(got), .got_cnt_o(got_cnt), .loads_o(loads));
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL at %0t: saw %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk({8'h00, rdata_o}, {8'h00, e});
  endtask : rd
  // Clock periods in system cycles, the transmit expectation queue and the receive comparison.
  always @(posedge clk_i) begin
    cyc++;
    if (tx_mclk_o && !prev[0]) {p_m, t_m} = {cyc - t_m, cyc};
    if (tx_bclk_o && !prev[1]) {p_b, t_b} = {cyc - t_b, cyc};
    if (tx_lrck_o && !prev[2]) {p_l, t_l} = {cyc - t_l, cyc};
    prev = {tx_lrck_o, tx_bclk_o, tx_mclk_o};
    if (tx_pop_o) begin
      tx_exp_q.push_back(tx_sample_i);
      tx_sample_i <= $random(seed);
    end
    if (rx_push_o && loads >= 2) begin
      npush++;
      chk(rx_sample_o, src[(loads - 2) % 64]);
    end
    if (cyc > 40000) begin
      err_count++;
      give_verdict();
    end
  end
  always @(got_cnt) if (tx_exp_q.size() > 1) chk(got, tx_exp_q[tx_exp_q.size() - 2]);
  initial begin
    tx_sample_i = 16'h1234;
    foreach (src[i]) src[i] = $random(seed);
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1 chk(16'({tx_mclk_o, rx_mclk_o, tx_bclk_oe_o, rx_mclk_oe_o, rx_bclk_oe_o, rx_lrck_oe_o}), 16'h001F);
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(ra[0], cv[0]);
    wr(ra[4], cv[4]);
    repeat (50) @(posedge clk_i);
    chk(16'(p_m + p_b + p_l), 16'h0000);
    foreach (ra[i]) wr(ra[i], cv[i]);
    foreach (ra[i]) rd(ra[i], i < 10 ? cv[i] : 8'h00);
    repeat (4000) @(posedge clk_i);
    wr(`RX_MODE_ADDR, 8'h1F);
    repeat (8000) @(posedge clk_i);
    chk(16'(p_m), 16'h0006);
    chk(16'(p_b), 16'h0018);
    chk(16'(p_l), 16'h03C0);
    chk(16'(npush > 8), 16'h0001);
    wr(`TX_MODE_ADDR, 8'h5E);
    wr(`TX_CTRL_ADDR, 8'h00);
    repeat (10) @(posedge clk_i);
    chk(16'({tx_sd_o, tx_lrck_o, tx_bclk_o, tx_bclk_oe_o}), 16'h0000);
    give_verdict();
  end
endmodule : i2s_tx_rx_interface_tb
bind i2s_tx_rx_interface i2s_tx_rx_checker i2s_tx_rx_checker_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .tx_mclk_oe_o(tx_mclk_oe_o),
  .tx_bclk_oe_o(tx_bclk_oe_o), .tx_lrck_oe_o(tx_lrck_oe_o), .tx_bclk_o(tx_bclk_o), .tx_lrck_o(tx_lrck_o),
  .tx_sd_o(tx_sd_o), .rx_lrck_o(rx_lrck_o), .tx_pop_o(tx_pop_o), .rx_push_o(rx_push_o));
